// ### verilog/lgoe_regs.vh
// Constants of the light grid output evaluator.
// Assumes one beam vector per scan, beam 1 in bit 0.
`ifndef LGOE_REGS_VH
`define LGOE_REGS_VH

// Grid size and measurement width
`define LGOE_BEAMS      32
`define LGOE_CNT_W      7
`define LGOE_BEAMS_CNT  7'h20

// Output function select
`define LGOE_FN_DYN      3'h0
`define LGOE_FN_OBJCNT   3'h1
`define LGOE_FN_HOLECNT  3'h2
`define LGOE_FN_DIM      3'h3
`define LGOE_FN_OBJPOS   3'h4
`define LGOE_FN_HOLEPOS  3'h5
`define LGOE_FN_DIAG     3'h6

// Comparison modes
`define LGOE_CMP_GE  2'h0
`define LGOE_CMP_LE  2'h1
`define LGOE_CMP_EQ  2'h2

// Diagnostic enable bit positions
`define LGOE_DG_CONTAM  0
`define LGOE_DG_SHORT   1
`define LGOE_DG_TEACH   2
`define LGOE_DG_HW      3
`define LGOE_DG_SYNC    4
`define LGOE_DG_TQUAL   5
`define LGOE_DG_PQUAL   6
`define LGOE_DG_W       7

// Reset values
`define LGOE_OUT_RST    1'h0
`define LGOE_VAL_RST    7'h00

`endif

// ### verilog/lgoe_eval.v
// Switching output evaluator of a measuring light grid.
// Assumes beamBlocked is stable in the cycle where scanDone pulses.
`timescale 1ns/1ns
`include "lgoe_regs.vh"

// What this block does
// (RQ1) Dynamic recognition matches objects anywhere, several allowed
// (RQ2) Zero tolerance needs exact configured object size
// (RQ3) Tolerance t accepts size minus t to plus t
// (RQ4) Object detection compares blocked count ge/le/eq n
// (RQ5) Consecutive option uses longest contiguous blocked run
// (RQ6) Otherwise total blocked beams across all objects
// (RQ7) Hole detection compares made count ge/le/eq n
// (RQ8) Holes: single gap or total made beams
// (RQ9) Dimension selects outside or inside measurement
// (RQ10) Largest object alone gives the dimension
// (RQ11) Dimension compared ge/le/eq n beams
// (RQ12) Object position is centre of largest object
// (RQ13) Object centre compared ge/le/eq beam n
// (RQ14) Hole position is centre of largest hole
// (RQ15) Hole centre compared ge/le/eq beam n
// (RQ16) Contamination warning drives output when enabled
// (RQ17) Wiring short-circuit drives output when enabled
// (RQ18) Failed teach-in drives output when enabled
// (RQ19) Hardware fault drives output when enabled
// (RQ20) Synchronisation link fault drives output when enabled
// (RQ21) Teach-in quality below percent limit drives output
// (RQ22) Process quality below percent limit drives output
// (RQ23) Diagnostics ORed; outputs updated once per scan
module lgoe_eval
(
  // Clock and reset
  input  wire                      clk,
  input  wire                      arst_n,

  // Scan input, sampled with scanDone
  input  wire [`LGOE_BEAMS-1:0]    beamBlocked,
  input  wire                      scanDone,

  // Measurement configuration
  input  wire [2:0]                funcSel,
  input  wire [1:0]                cmpMode,
  input  wire [`LGOE_CNT_W-1:0]    thresholdN,
  input  wire                      consecOnly,
  input  wire                      dimInside,
  input  wire [`LGOE_CNT_W-1:0]    objSize,
  input  wire [`LGOE_CNT_W-1:0]    tolerance,

  // Diagnostic sources and limits
  input  wire [`LGOE_DG_W-1:0]     diagEnable,
  input  wire                      contamWarn,
  input  wire                      shortCircuit,
  input  wire                      teachError,
  input  wire                      hwFault,
  input  wire                      syncFault,
  input  wire [6:0]                teachQuality,
  input  wire [6:0]                processQuality,
  input  wire [6:0]                teachQualLimit,
  input  wire [6:0]                procQualLimit,

  // Results, registered
  output reg                       switchingOutput,
  output reg  [`LGOE_CNT_W-1:0]    measValue,
  output reg                       resultStrobe
);

  function cmpSel;
    input [1:0]              mode;
    input [`LGOE_CNT_W-1:0]  v;
    input [`LGOE_CNT_W-1:0]  n;
    begin
      case (mode)
        `LGOE_CMP_GE:
        begin
          cmpSel = (v >= n);
        end
        `LGOE_CMP_LE:
        begin
          cmpSel = (v <= n);
        end
        `LGOE_CMP_EQ:
        begin
          cmpSel = (v == n);
        end
        // Mode 3 never matches
        default:
        begin
          cmpSel = 1'b0;
        end
      endcase
    end
  endfunction

  // Centre beam number (1-based) of a run
  function [`LGOE_CNT_W-1:0] centreOf;
    input [`LGOE_CNT_W-1:0]  start;
    input [`LGOE_CNT_W-1:0]  len;
    reg   [`LGOE_CNT_W-1:0]  half;
    begin
      half = (len - 7'h01) >> 1;
      centreOf = start + 7'h01 + half;
    end
  endfunction

  integer                  i;
  reg                      bitB;
  reg                      prevB;
  reg                      seenB;
  reg                      anyObj;
  reg                      allOk;
  reg [`LGOE_CNT_W-1:0]    runLen;
  reg [`LGOE_CNT_W-1:0]    runStart;
  reg [`LGOE_CNT_W-1:0]    totB;
  reg [`LGOE_CNT_W-1:0]    totM;
  reg [`LGOE_CNT_W-1:0]    maxB;
  reg [`LGOE_CNT_W-1:0]    maxBStart;
  reg [`LGOE_CNT_W-1:0]    maxM;
  reg [`LGOE_CNT_W-1:0]    maxMStart;
  reg [`LGOE_CNT_W-1:0]    maxIn;
  reg [`LGOE_CNT_W-1:0]    tolLo;
  reg [`LGOE_CNT_W-1:0]    tolHi;
  reg [`LGOE_CNT_W:0]      tolSum;

  // Tolerance window around the configured object size
  always @*
  begin
    // Low edge clamps at zero, high edge saturates instead of wrapping
    tolLo  = (objSize > tolerance) ? (objSize - tolerance) : `LGOE_VAL_RST; // [RQ3]
    tolSum = {1'h0, objSize} + {1'h0, tolerance};
    if (tolSum[`LGOE_CNT_W])
      tolHi = 7'h7F; // [RQ3]
    else
      tolHi = tolSum[`LGOE_CNT_W-1:0]; // [RQ2] [RQ3]
  end

  // Walk the beams once, closing runs at every change and at the end
  always @*
  begin
    prevB     = beamBlocked[0];
    seenB     = 1'b0;
    anyObj    = 1'b0;
    allOk     = 1'b1;
    runLen    = `LGOE_VAL_RST;
    runStart  = `LGOE_VAL_RST;
    totB      = `LGOE_VAL_RST;
    totM      = `LGOE_VAL_RST;
    maxB      = `LGOE_VAL_RST;
    maxBStart = `LGOE_VAL_RST;
    maxM      = `LGOE_VAL_RST;
    maxMStart = `LGOE_VAL_RST;
    maxIn     = `LGOE_VAL_RST;
    bitB      = 1'b0;
    // One pass past the last beam closes the final run
    for (i = 0; i <= `LGOE_BEAMS; i = i + 1)
    begin
      if (i < `LGOE_BEAMS)
        bitB = beamBlocked[i];
      else
        bitB = ~prevB;
      if (bitB != prevB && runLen != `LGOE_VAL_RST)
      begin
        if (prevB)
        begin
          anyObj = 1'b1; // [RQ1]
          if (runLen < tolLo || runLen > tolHi)
            allOk = 1'b0; // [RQ1] [RQ2] [RQ3]
          // Strict greater keeps the lowest-numbered run on ties
          if (runLen > maxB)
          begin
            maxB      = runLen; // [RQ5] [RQ10]
            maxBStart = runStart; // [RQ12]
          end
          seenB = 1'b1;
        end
        else
        begin
          if (runLen > maxM)
          begin
            maxM      = runLen; // [RQ8]
            maxMStart = runStart; // [RQ14]
          end
          // Gap enclosed by blocked beams on both sides
          if (i < `LGOE_BEAMS && seenB && runLen > maxIn)
            maxIn = runLen; // [RQ9]
        end
        // Next run begins at this beam, zero-based
        runLen   = `LGOE_VAL_RST;
        runStart = i[`LGOE_CNT_W-1:0];
      end
      if (i < `LGOE_BEAMS)
      begin
        runLen = runLen + 7'h01;
        if (bitB)
          totB = totB + 7'h01; // [RQ6]
        else
          totM = totM + 7'h01; // [RQ8]
      end
      prevB = bitB;
    end
  end

  reg                      diagHit;
  reg [`LGOE_DG_W-1:0]     diagCond;
  reg                      outNext;
  reg [`LGOE_CNT_W-1:0]    valNext;

  // One condition per enable bit, same order as diagEnable
  always @*
  begin
    diagCond                  = 7'h00;
    diagCond[`LGOE_DG_CONTAM] = contamWarn; // [RQ16]
    diagCond[`LGOE_DG_SHORT]  = shortCircuit; // [RQ17]
    diagCond[`LGOE_DG_TEACH]  = teachError; // [RQ18]
    diagCond[`LGOE_DG_HW]     = hwFault; // [RQ19]
    diagCond[`LGOE_DG_SYNC]   = syncFault; // [RQ20]
    // Strict compare: quality equal to the limit is still good
    diagCond[`LGOE_DG_TQUAL]  = (teachQuality < teachQualLimit); // [RQ21]
    diagCond[`LGOE_DG_PQUAL]  = (processQuality < procQualLimit); // [RQ22]
  end

  // Any enabled condition raises the output
  always @*
  begin
    diagHit = |(diagCond & diagEnable); // [RQ23]
  end

  // Selected function and its measured value
  always @*
  begin
    outNext = 1'b0;
    valNext = `LGOE_VAL_RST;
    case (funcSel)
      `LGOE_FN_DYN:
      begin
        valNext = maxB;
        outNext = anyObj & allOk; // [RQ1] [RQ2] [RQ3]
      end
      `LGOE_FN_OBJCNT:
      begin
        valNext = consecOnly ? maxB : totB; // [RQ5] [RQ6]
        outNext = cmpSel(cmpMode, valNext, thresholdN); // [RQ4]
      end
      `LGOE_FN_HOLECNT:
      begin
        valNext = consecOnly ? maxM : totM; // [RQ8]
        outNext = cmpSel(cmpMode, valNext, thresholdN); // [RQ7]
      end
      `LGOE_FN_DIM:
      begin
        valNext = dimInside ? maxIn : maxB; // [RQ9] [RQ10]
        outNext = cmpSel(cmpMode, valNext, thresholdN); // [RQ11]
      end
      `LGOE_FN_OBJPOS:
      begin
        // No object: output low, value zero
        if (maxB != `LGOE_VAL_RST)
        begin
          valNext = centreOf(maxBStart, maxB); // [RQ12]
          outNext = cmpSel(cmpMode, valNext, thresholdN); // [RQ13]
        end
      end
      `LGOE_FN_HOLEPOS:
      begin
        // No hole: output low, value zero
        if (maxM != `LGOE_VAL_RST)
        begin
          valNext = centreOf(maxMStart, maxM); // [RQ14]
          outNext = cmpSel(cmpMode, valNext, thresholdN); // [RQ15]
        end
      end
      `LGOE_FN_DIAG:
      begin
        outNext = diagHit; // [RQ23]
      end
      default:
      begin
        outNext = 1'b0;
        valNext = `LGOE_VAL_RST;
      end
    endcase
  end

  // Results are taken once per completed scan
  // Strobe follows every scan, results change only on scanDone
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      switchingOutput <= `LGOE_OUT_RST;
      measValue       <= `LGOE_VAL_RST;
      resultStrobe    <= 1'b0;
    end
    else
    begin
      resultStrobe <= scanDone;
      if (scanDone)
      begin
        switchingOutput <= outNext; // [RQ23]
        measValue       <= valNext;
      end
    end
  end

endmodule

// ### test/lgoe_eval_props.sv
// Port checker for the light grid output evaluator.
// Assumes binding to lgoe_eval; single clock domain.
`timescale 1ns/1ns
module lgoe_eval_props
(
  input wire       clk,
  input wire       arst_n,
  input wire       scanDone,
  input wire [2:0] funcSel,
  input wire [1:0] cmpMode,
  input wire [6:0] thresholdN,
  input wire [6:0] diagEnable,
  input wire       contamWarn,
  input wire       shortCircuit,
  input wire       teachError,
  input wire       hwFault,
  input wire       syncFault,
  input wire [6:0] teachQuality,
  input wire [6:0] processQuality,
  input wire [6:0] teachQualLimit,
  input wire [6:0] procQualLimit,
  input wire       switchingOutput,
  input wire [6:0] measValue,
  input wire       resultStrobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_diag(c);
    scanDone && funcSel == 3'h6 && c;
  endsequence
  property p_diag(c);
    s_diag(c) |=> switchingOutput;
  endproperty
  a_strobe_scan: assert property (scanDone |=> resultStrobe)
    else $error("strobe missing");
  a_strobe_idle: assert property (!scanDone |=> !resultStrobe)
    else $error("stray strobe");
  a_out_hold: assert property (!scanDone |=> $stable({switchingOutput, measValue}))
    else $error("output moved between scans");
  a_diag_contam: assert property (p_diag(diagEnable[0] && contamWarn))
    else $error("contamination not reported");
  a_diag_short: assert property (p_diag(diagEnable[1] && shortCircuit))
    else $error("short not reported");
  a_diag_teach: assert property (p_diag(diagEnable[2] && teachError))
    else $error("teach error not reported");
  a_diag_hw: assert property (p_diag(diagEnable[3] && hwFault))
    else $error("hardware fault not reported");
  a_diag_sync: assert property (p_diag(diagEnable[4] && syncFault))
    else $error("sync fault not reported");
  a_teach_qual: assert property (p_diag(diagEnable[5] && teachQuality < teachQualLimit))
    else $error("teach quality not reported");
  a_proc_qual: assert property (p_diag(diagEnable[6] && processQuality < procQualLimit))
    else $error("process quality not reported");
  a_objcnt_ge: assert property (scanDone && funcSel == 3'h1 && cmpMode == 2'h0 |=>
    measValue == 7'h00 || switchingOutput == (measValue >= $past(thresholdN)))
    else $error("object count compare wrong");
endmodule
bind lgoe_eval lgoe_eval_props u_lgoe_eval_props (.clk, .arst_n, .scanDone, .funcSel,
  .cmpMode, .thresholdN, .diagEnable, .contamWarn, .shortCircuit, .teachError, .hwFault,
  .syncFault, .teachQuality, .processQuality, .teachQualLimit, .procQualLimit,
  .switchingOutput, .measValue, .resultStrobe);

// ### test/lgoe_ctrl_model.sv
// Controller model latching one result per strobe.
// Assumes resultStrobe marks a settled result.
`timescale 1ns/1ns
module lgoe_ctrl_model
(
  input  wire       clk,
  input  wire       arst_n,
  input  wire       switchingOutput,
  input  wire [6:0] measValue,
  input  wire       resultStrobe,
  output reg        seenOut,
  output reg  [6:0] seenMeas
);
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seenOut  <= 1'h0;
      seenMeas <= 7'h00;
    end
    else if (resultStrobe)
    begin
      seenOut  <= switchingOutput;
      seenMeas <= measValue;
    end
  end
endmodule

// ### test/lgoe_eval_tb_top.sv
// Self-checking bench for the light grid output evaluator.
// Assumes design, checker and controller model compile first.
`timescale 1ns/1ns
module lgoe_eval_tb_top;
  reg        clk = 1'h0, arst_n = 1'h0, scanDone = 1'h0, consecOnly = 1'h0, dimInside = 1'h0;
  reg [31:0] beamBlocked = 32'h00003F0F;
  reg [2:0]  funcSel = 3'h0;
  reg [1:0]  cmpMode = 2'h0;
  reg [6:0]  thresholdN = 7'h00, objSize = 7'h05, tolerance = 7'h01, diagEnable = 7'h00;
  reg        contamWarn = 1'h1, shortCircuit = 1'h1, teachError = 1'h1, hwFault = 1'h1;
  reg        syncFault = 1'h1;
  reg [6:0]  teachQuality = 7'h32, processQuality = 7'h32;
  reg [6:0]  teachQualLimit = 7'h3C, procQualLimit = 7'h3C;
  wire       switchingOutput, resultStrobe, seenOut;
  wire [6:0] measValue, seenMeas;
  integer    fails = 0, checks = 0, i;
  always #10 clk = ~clk;
  lgoe_eval u_lgoe_eval (.clk, .arst_n, .beamBlocked, .scanDone, .funcSel, .cmpMode,
    .thresholdN, .consecOnly, .dimInside, .objSize, .tolerance, .diagEnable, .contamWarn,
    .shortCircuit, .teachError, .hwFault, .syncFault, .teachQuality, .processQuality,
    .teachQualLimit, .procQualLimit, .switchingOutput, .measValue, .resultStrobe);
  lgoe_ctrl_model u_lgoe_ctrl_model (.clk, .arst_n, .switchingOutput, .measValue,
    .resultStrobe, .seenOut, .seenMeas);
  task chk(input string nm, input [6:0] exp, input [6:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // One scan; beams inverted after sampling must not leak
  task run(input [2:0] f, input [1:0] m, input [6:0] n, input eo, input [6:0] em);
  begin
    @(posedge clk);
    #1;
    funcSel = f;
    cmpMode = m;
    thresholdN = n;
    scanDone = 1'h1;
    @(posedge clk);
    #1;
    scanDone = 1'h0;
    beamBlocked = ~beamBlocked;
    chk("strobe", 7'h01, resultStrobe);
    @(posedge clk);
    #1;
    beamBlocked = ~beamBlocked;
    chk("out", eo, seenOut);
    chk("meas", em, seenMeas);
    chk("held", eo, switchingOutput);
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #40000;
    fails = fails + 1;
    wrap_up;
  end
  // Objects at beams 1-4 and 9-14, holes 5-8 and 15-32
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'h1;
    run(3'h0, 2'h0, 7'h00, 1'h1, 7'h06);
    tolerance = 7'h00;
    objSize = 7'h06;
    run(3'h0, 2'h0, 7'h00, 1'h0, 7'h06);
    beamBlocked = 32'h00F00F00;
    objSize = 7'h04;
    run(3'h0, 2'h0, 7'h00, 1'h1, 7'h04);
    tolerance = 7'h01;
    objSize = 7'h05;
    run(3'h0, 2'h0, 7'h00, 1'h1, 7'h04);
    objSize = 7'h03;
    run(3'h0, 2'h0, 7'h00, 1'h1, 7'h04);
    objSize = 7'h06;
    run(3'h0, 2'h0, 7'h00, 1'h0, 7'h04);
    beamBlocked = 32'h00003F0F;
    run(3'h1, 2'h0, 7'h0A, 1'h1, 7'h0A);
    run(3'h1, 2'h1, 7'h09, 1'h0, 7'h0A);
    run(3'h1, 2'h2, 7'h0A, 1'h1, 7'h0A);
    run(3'h1, 2'h3, 7'h0A, 1'h0, 7'h0A);
    run(3'h2, 2'h0, 7'h16, 1'h1, 7'h16);
    run(3'h2, 2'h1, 7'h15, 1'h0, 7'h16);
    consecOnly = 1'h1;
    run(3'h1, 2'h2, 7'h06, 1'h1, 7'h06);
    run(3'h1, 2'h0, 7'h07, 1'h0, 7'h06);
    run(3'h2, 2'h2, 7'h12, 1'h1, 7'h12);
    run(3'h3, 2'h2, 7'h06, 1'h1, 7'h06);
    run(3'h3, 2'h1, 7'h05, 1'h0, 7'h06);
    dimInside = 1'h1;
    run(3'h3, 2'h2, 7'h04, 1'h1, 7'h04);
    run(3'h3, 2'h0, 7'h05, 1'h0, 7'h04);
    run(3'h4, 2'h0, 7'h0B, 1'h1, 7'h0B);
    run(3'h4, 2'h1, 7'h0A, 1'h0, 7'h0B);
    run(3'h4, 2'h2, 7'h0B, 1'h1, 7'h0B);
    run(3'h5, 2'h2, 7'h17, 1'h1, 7'h17);
    run(3'h5, 2'h0, 7'h18, 1'h0, 7'h17);
    run(3'h5, 2'h1, 7'h17, 1'h1, 7'h17);
    run(3'h7, 2'h1, 7'h17, 1'h0, 7'h00);
    for (i = 0; i < 7; i = i + 1)
    begin
      diagEnable = 7'h01 << i;
      run(3'h6, 2'h0, 7'h00, 1'h1, 7'h00);
    end
    {contamWarn, shortCircuit, teachError, hwFault, syncFault} = 5'h00;
    teachQuality = 7'h3C;
    processQuality = 7'h3C;
    diagEnable = 7'h7F;
    run(3'h6, 2'h0, 7'h00, 1'h0, 7'h00);
    contamWarn = 1'h1;
    run(3'h6, 2'h0, 7'h00, 1'h1, 7'h00);
    diagEnable = 7'h00;
    run(3'h6, 2'h0, 7'h00, 1'h0, 7'h00);
    wrap_up;
  end
endmodule
